// >>> design/hpb_unpack.sv
// host pixel bus: strobe capture, pixel unpacking, read path, panel enables
`timescale 1ns/1ps
module hpb_unpack
   import hpb_pkg::*;
(
   input wire logic SYS_CLK_I, // 10 MHz reference clock
   input wire logic SYS_RST_I, // sync reset, high
   input wire logic [2:0] WIDTH_SEL_I, // bus width / packing select
   input wire logic CS_N_I, // chip select, low
   input wire logic WR_N_I, // write strobe, low
   input wire logic RD_N_I, // read strobe, low
   input wire logic COMMAND_DATA_SELECT_I, // 0 command, 1 data
   input wire logic [HPB_BUS_W-1:0] BUS_I, // host data in
   output logic [HPB_BUS_W-1:0] BUS_O, // read data out
   output logic BUS_OE_O, // high while driving bus
   input wire logic [HPB_BUS_W-1:0] RDATA_I, // data to return on reads
   output logic RDATA_ACK_O, // pulse: read word consumed
   output logic RD_VALID_O, // read data valid on bus
   output logic CMD_VALID_O, // pulse: command byte received
   output logic [7:0] CMD_O, // received command code
   output logic PARAM_VALID_O, // pulse: parameter word (not pixel)
   output logic PIX_VALID_O, // pulse: full pixel assembled
   output logic [HPB_PIX_W-1:0] PIX_O, // pixel r8 g8 b8, msb aligned
   input wire logic PIXEL_MODE_I, // 1: data writes are pixels
   input wire logic PANEL_ON_INPUT_I, // panel-on pin
   input wire logic BACKLIGHT_ON_I, // backlight enable pin
   output logic PANEL_EN_O, // panel image enable
   output logic BACKLIGHT_EN_O // backlight drive
);
   logic wr_fire;
   logic [1:0] phase;
   logic [1:0] next_phase;
   logic [17:0] hold;
   logic [17:0] next_hold;
   logic [HPB_PIX_W-1:0] pix;
   logic [HPB_PIX_W-1:0] next_pix;
   logic pix_v;
   logic next_pix_v;
   logic cmd_v;
   logic next_cmd_v;
   logic par_v;
   logic next_par_v;
   logic [7:0] cmd;
   logic [7:0] next_cmd;
   logic [HPB_CNT_W-1:0] rd_cnt;
   logic [HPB_CNT_W-1:0] next_rd_cnt;
   logic rd_act;
   logic [HPB_BUS_W-1:0] rd_q;
   logic [HPB_BUS_W-1:0] next_rd_q;
   logic panel;
   logic blight;
   hpb_width_t wsel;

   assign wsel = hpb_width_t'(WIDTH_SEL_I);

   hpb_strobe u_wr (
      .clk_i(SYS_CLK_I),
      .rst_i(SYS_RST_I),
      .cs_n_i(CS_N_I),
      .str_n_i(WR_N_I),
      .fire_o(wr_fire)
   );

   always_comb begin
      next_phase = phase;
      next_hold = hold;
      next_pix = pix;
      next_pix_v = 1'b0;
      next_cmd_v = 1'b0;
      next_par_v = 1'b0;
      next_cmd = cmd;
      if (wr_fire && !COMMAND_DATA_SELECT_I) begin
         next_cmd = BUS_I[7:0];
         next_cmd_v = 1'b1;
         next_phase = 2'h0;
      end else if (wr_fire && !PIXEL_MODE_I) begin
         next_par_v = 1'b1;
         next_pix = BUS_I;
      end else if (wr_fire) begin
         unique case (wsel)
            HPB_W24: begin
               next_pix = BUS_I;
               next_pix_v = 1'b1;
            end
            HPB_W18: begin
               next_pix = {BUS_I[17:12], 2'h0, BUS_I[11:6], 2'h0, BUS_I[5:0], 2'h0};
               next_pix_v = 1'b1;
            end
            HPB_W16: begin
               next_pix = {BUS_I[15:11], 3'h0, BUS_I[10:5], 2'h0, BUS_I[4:0], 3'h0};
               next_pix_v = 1'b1;
            end
            HPB_W16X: begin
               unique case (phase)
                  2'h0: begin
                     next_hold = {BUS_I[15:10], BUS_I[7:2], 6'h00};
                     next_phase = 2'h1;
                  end
                  2'h1: begin
                     next_pix = {hold[17:12], 2'h0, hold[11:6], 2'h0, BUS_I[15:10], 2'h0};
                     next_pix_v = 1'b1;
                     next_hold = {BUS_I[7:2], 12'h000};
                     next_phase = 2'h2;
                  end
                  default: begin
                     next_pix = {hold[17:12], 2'h0, BUS_I[15:10], 2'h0, BUS_I[7:2], 2'h0};
                     next_pix_v = 1'b1;
                     next_phase = 2'h0;
                  end
               endcase
            end
            HPB_W9: begin
               if (phase == 2'h0) begin
                  next_hold = {BUS_I[8:0], 9'h000};
                  next_phase = 2'h1;
               end else begin
                  next_pix = {hold[17:12], 2'h0, hold[11:9], BUS_I[8:6], 2'h0, BUS_I[5:0], 2'h0};
                  next_pix_v = 1'b1;
                  next_phase = 2'h0;
               end
            end
            HPB_W8: begin
               unique case (phase)
                  2'h0: begin
                     next_hold = {BUS_I[7:2], 12'h000};
                     next_phase = 2'h1;
                  end
                  2'h1: begin
                     next_hold = {hold[17:12], BUS_I[7:2], 6'h00};
                     next_phase = 2'h2;
                  end
                  default: begin
                     next_pix = {hold[17:12], 2'h0, hold[11:6], 2'h0, BUS_I[7:2], 2'h0};
                     next_pix_v = 1'b1;
                     next_phase = 2'h0;
                  end
               endcase
            end
            default: begin
               next_phase = 2'h0;
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         phase <= 2'h0;
         hold <= 18'h00000;
         pix <= 24'h000000;
         pix_v <= 1'b0;
         cmd_v <= 1'b0;
         par_v <= 1'b0;
         cmd <= 8'h00;
      end else begin
         phase <= next_phase;
         hold <= next_hold;
         pix <= next_pix;
         pix_v <= next_pix_v;
         cmd_v <= next_cmd_v;
         par_v <= next_par_v;
         cmd <= next_cmd;
      end
   end

   // read path: first valid data only after the fixed read latency
   always_comb begin
      next_rd_cnt = rd_cnt;
      next_rd_q = rd_q;
      if (!rd_act) begin
         next_rd_cnt = '0;
      end else if (rd_cnt != HPB_FRD_CNT) begin
         next_rd_cnt = rd_cnt + HPB_CNT_W'(1);
         if (rd_cnt == HPB_FRD_CNT - HPB_CNT_W'(1)) begin
            next_rd_q = RDATA_I;
         end
      end
   end
   assign rd_act = ~CS_N_I & ~RD_N_I;

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         rd_cnt <= '0;
         rd_q <= 24'h000000;
         panel <= 1'b0;
         blight <= 1'b0;
      end else begin
         rd_cnt <= next_rd_cnt;
         rd_q <= next_rd_q;
         panel <= PANEL_ON_INPUT_I;
         blight <= BACKLIGHT_ON_I;
      end
   end

   assign RD_VALID_O = rd_act & (rd_cnt == HPB_FRD_CNT);
   assign BUS_OE_O = rd_act;
   assign BUS_O = rd_q;
   assign RDATA_ACK_O = rd_act & (rd_cnt == HPB_FRD_CNT - HPB_CNT_W'(1));
   assign PIX_O = pix;
   assign PIX_VALID_O = pix_v;
   assign CMD_O = cmd;
   assign CMD_VALID_O = cmd_v;
   assign PARAM_VALID_O = par_v;
   assign PANEL_EN_O = panel;
   assign BACKLIGHT_EN_O = blight;

   // checks
   sequence s_wr_fire;
      wr_fire && COMMAND_DATA_SELECT_I && PIXEL_MODE_I;
   endsequence
   property p_w24;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (s_wr_fire and (wsel == HPB_W24)) |=> PIX_VALID_O && PIX_O == $past(BUS_I);
   endproperty
   a_w24: assert property (p_w24) else $error("24-bit pixel wrong");
   property p_w18;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (s_wr_fire and (wsel == HPB_W18)) |=> PIX_VALID_O && PIX_O[23:18] == $past(BUS_I[17:12]);
   endproperty
   a_w18: assert property (p_w18) else $error("18-bit red wrong");
   property p_w16;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (s_wr_fire and (wsel == HPB_W16)) |=> PIX_O[7:3] == $past(BUS_I[4:0]);
   endproperty
   a_w16: assert property (p_w16) else $error("565 blue wrong");
   property p_w8;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (s_wr_fire and (wsel == HPB_W8) and (phase == 2'h0)) |=> !PIX_VALID_O;
   endproperty
   a_w8: assert property (p_w8) else $error("8-bit first byte gave pixel");
   property p_w9;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (s_wr_fire and (wsel == HPB_W9) and (phase == 2'h1)) |=> PIX_VALID_O;
   endproperty
   a_w9: assert property (p_w9) else $error("9-bit second cycle no pixel");
   property p_w16x;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (s_wr_fire and (wsel == HPB_W16X) and (phase == 2'h0)) |=> phase == 2'h1 && !PIX_VALID_O;
   endproperty
   a_w16x: assert property (p_w16x) else $error("alt 16-bit first word wrong");
   property p_cmd;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      (wr_fire && !COMMAND_DATA_SELECT_I) |=> CMD_VALID_O && !PIX_VALID_O && CMD_O == $past(BUS_I[7:0]);
   endproperty
   a_cmd: assert property (p_cmd) else $error("command not captured");
   property p_frd;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      $rose(rd_act) |-> !RD_VALID_O [*5];
   endproperty
   a_frd: assert property (p_frd) else $error("read data too early");
   property p_panel;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      ##1 PANEL_EN_O == $past(PANEL_ON_INPUT_I) && BACKLIGHT_EN_O == $past(BACKLIGHT_ON_I);
   endproperty
   a_panel: assert property (p_panel) else $error("enable pin not followed");
endmodule // hpb_unpack

// >>> inc/hpb_pkg.sv
// constants and types for the host pixel bus unpacker
// Behaviour
// - accept pixels over 8, 9, 16, 18 or 24 bit bus, packing chosen by width
// - 24-bit: one cycle, red top byte, green middle, blue low byte
// - 18-bit: one cycle, red 17..12, green 11..6, blue 5..0
// - 16-bit 565: one word, five red top, six green middle, five blue low
// - 9-bit: two cycles, red plus green high, then green low plus blue
// - panel image enabled while panel-on input high, blanked while low
// - reference clock period at least 9 ns; bus minimums counted in it
// - external clock up to 120 MHz bypassed, 2.5..50 with PLL, crystal 2.5..10
package hpb_pkg;
   typedef enum logic [2:0] {
      HPB_W8 = 3'h0,
      HPB_W9 = 3'h1,
      HPB_W16 = 3'h2,
      HPB_W16X = 3'h3,
      HPB_W18 = 3'h4,
      HPB_W24 = 3'h5
   } hpb_width_t;
   localparam int unsigned HPB_CLK_PERIOD_NS = 100;
   localparam int unsigned HPB_REF_MIN_NS = 9;
   localparam int unsigned HPB_FIRST_READ_CYC = 5;
   localparam int unsigned HPB_CNT_W = 3;
   localparam logic [HPB_CNT_W-1:0] HPB_FRD_CNT = HPB_CNT_W'(HPB_FIRST_READ_CYC);
   localparam int unsigned HPB_BUS_W = 24;
   localparam int unsigned HPB_PIX_W = 24;
endpackage

// >>> design/hpb_strobe.sv
// strobe edge detector for the host bus
`timescale 1ns/1ps
module hpb_strobe (
   input wire logic clk_i, // clock
   input wire logic rst_i, // sync reset
   input wire logic cs_n_i, // chip select, active low
   input wire logic str_n_i, // strobe, active low
   output logic fire_o // one cycle at strobe release while selected
);
   logic held;
   logic next_held;
   always_comb begin
      next_held = ~cs_n_i & ~str_n_i;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         held <= 1'b0;
      end else begin
         held <= next_held;
      end
   end
   // data is latched on the first clock edge after the strobe rises, not on the strobe edge as the bus does
   assign fire_o = held & ~next_held;
endmodule // hpb_strobe

// >>> dv/hpb_host_model.sv
// host microcontroller model driving the 8080-style bus
`timescale 1ns/1ps
module hpb_host_model
   import hpb_pkg::*;
(
   input wire logic clk_i, // bus clock
   input wire logic [HPB_BUS_W-1:0] bus_i, // device read data
   input wire logic rd_valid_i, // device read data valid
   output logic cs_n_o = 1'b1, // chip select, low
   output logic wr_n_o = 1'b1, // write strobe, low
   output logic rd_n_o = 1'b1, // read strobe, low
   output logic rs_o = 1'b1, // 0 command, 1 data
   output logic [HPB_BUS_W-1:0] bus_o = '0 // host data
);
   task automatic write(input logic rs, input logic [HPB_BUS_W-1:0] d);
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      wr_n_o <= 1'b0;
      rs_o <= rs;
      bus_o <= d;
      @(posedge clk_i);
      cs_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      // data stays one more cycle: the device takes it in the cycle after the strobe rises
      @(posedge clk_i);
      // released lines show the inverse so a stale capture cannot pass
      bus_o <= ~d;
   endtask
   task automatic read(output logic [HPB_BUS_W-1:0] d, output int n);
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      rd_n_o <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (rd_valid_i !== 1'b1 && n < 50);
      d = bus_i;
      cs_n_o <= 1'b1;
      rd_n_o <= 1'b1;
   endtask
endmodule // hpb_host_model

// >>> dv/tb.sv
// self-checking bench for the host pixel bus unpacker
`timescale 1ns/1ps
module tb;
   import hpb_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] width_sel = 3'h5;
   logic pixel_mode = 1'b1;
   logic panel_in = 1'b0;
   logic bl_in = 1'b0;
   logic [23:0] rdata = '0;
   logic cs_n, wr_n, rd_n, rs, bus_oe, rdata_ack, rd_valid, cmd_valid, param_valid, pix_valid, panel_en, bl_en;
   logic [23:0] bus_in, bus_out, pix;
   logic [7:0] cmd;
   logic [26:0] exp_q[$];
   int n_mismatch = 0;
   int num_checks = 0;
   int seed = 16;
   int cycles = 0;
   int n_ack = 0;
   always #50 clk = ~clk;
   hpb_host_model u_host (.clk_i(clk), .bus_i(bus_out), .rd_valid_i(rd_valid), .cs_n_o(cs_n),
      .wr_n_o(wr_n), .rd_n_o(rd_n), .rs_o(rs), .bus_o(bus_in));
   hpb_unpack u_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .WIDTH_SEL_I(width_sel), .CS_N_I(cs_n),
      .WR_N_I(wr_n), .RD_N_I(rd_n), .COMMAND_DATA_SELECT_I(rs), .BUS_I(bus_in), .BUS_O(bus_out),
      .BUS_OE_O(bus_oe), .RDATA_I(rdata), .RDATA_ACK_O(rdata_ack), .RD_VALID_O(rd_valid),
      .CMD_VALID_O(cmd_valid), .CMD_O(cmd), .PARAM_VALID_O(param_valid), .PIX_VALID_O(pix_valid),
      .PIX_O(pix), .PIXEL_MODE_I(pixel_mode), .PANEL_ON_INPUT_I(panel_in), .BACKLIGHT_ON_I(bl_in),
      .PANEL_EN_O(panel_en), .BACKLIGHT_EN_O(bl_en));
   task automatic check(input string what, input logic [26:0] got, input logic [26:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // expected words carry {pixel, command, parameter} flags above the value
   function automatic logic [26:0] e6(input logic [5:0] r, input logic [5:0] g, input logic [5:0] b);
      return {3'b100, r, 2'h0, g, 2'h0, b, 2'h0};
   endfunction
   task automatic cmdw(input logic [7:0] c);
      exp_q.push_back({3'b010, 16'h0, c});
      u_host.write(1'b0, {16'h0, c});
   endtask
   task automatic run_mode(input logic [2:0] m);
      logic [63:0] v;
      logic [5:0] r, g, b, r1, g1, b1;
      logic [1:0] j;
      for (int i = 0; i < 4; i++) begin
         v = {$random(seed), $random(seed)};
         {j, r1, g1, b1, r, g, b} = v[37:0];
         case (m)
            HPB_W24: begin
               exp_q.push_back({3'b100, v[63:40]});
               u_host.write(1'b1, v[63:40]);
            end
            HPB_W18: begin
               exp_q.push_back(e6(r, g, b));
               u_host.write(1'b1, {6'h0, r, g, b});
            end
            HPB_W16: begin
               exp_q.push_back({3'b100, v[63:59], 3'h0, v[55:50], 2'h0, v[47:43], 3'h0});
               u_host.write(1'b1, {8'h0, v[63:59], v[55:50], v[47:43]});
            end
            HPB_W9: begin
               exp_q.push_back(e6(r, g, b));
               u_host.write(1'b1, {15'h0, r, g[5:3]});
               u_host.write(1'b1, {15'h0, g[2:0], b});
            end
            HPB_W8: begin
               exp_q.push_back(e6(r, g, b));
               u_host.write(1'b1, {16'h0, r, j});
               u_host.write(1'b1, {16'h0, g, j});
               u_host.write(1'b1, {16'h0, b, j});
            end
            default: begin
               exp_q.push_back(e6(r, g, b));
               exp_q.push_back(e6(r1, g1, b1));
               u_host.write(1'b1, {8'h0, r, j, g, j});
               u_host.write(1'b1, {8'h0, b, j, r1, j});
               u_host.write(1'b1, {8'h0, g1, j, b1, j});
            end
         endcase
      end
   endtask
   always @(posedge clk) begin
      if ((pix_valid | cmd_valid | param_valid) === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("unexpected output", 27'h0, 27'h1);
         end else begin
            check("output word", {pix_valid, cmd_valid, param_valid, cmd_valid ? {16'h0, cmd} : pix},
               exp_q.pop_front());
         end
      end
      if (rdata_ack === 1'b1) begin
         n_ack++;
      end
      check("bus drive enable", {26'h0, bus_oe}, {26'h0, ~cs_n & ~rd_n});
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      logic [31:0] v;
      logic [23:0] d;
      int n;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int m = 0; m < 6; m++) begin
         @(posedge clk);
         width_sel <= m[2:0];
         cmdw(8'(m) + 8'h2c);
         run_mode(m[2:0]);
         $display("test width %0d done", m);
      end
      // a command in mid-pixel must restart the byte phase
      @(posedge clk);
      width_sel <= HPB_W8;
      u_host.write(1'b1, 24'h0000fc);
      u_host.write(1'b1, 24'h000080);
      cmdw(8'h3c);
      run_mode(HPB_W8);
      @(posedge clk);
      width_sel <= HPB_W24;
      pixel_mode <= 1'b0;
      v = $random(seed);
      exp_q.push_back({3'b001, v[23:0]});
      u_host.write(1'b1, v[23:0]);
      @(posedge clk);
      pixel_mode <= 1'b1;
      $display("test phase and parameter done");
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         rdata <= 24'($random(seed));
         u_host.read(d, n);
         check("read data", {3'h0, d}, {3'h0, rdata});
         check("read latency", {26'h0, n >= 5}, 27'h1);
      end
      check("read acknowledges", 27'(n_ack), 27'h3);
      $display("test reads done");
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         v = $random(seed);
         panel_in <= v[0];
         bl_in <= v[1];
         @(posedge clk);
         #1;
         check("panel enable", {26'h0, panel_en}, {26'h0, v[0]});
         check("backlight enable", {26'h0, bl_en}, {26'h0, v[1]});
      end
      $display("test enables done");
      repeat (10) @(posedge clk);
      check("pending outputs", 27'(exp_q.size()), 27'h0);
      complete_run();
   end
endmodule // tb
